// File: inc/pss_pkg.sv
// shared constants and types for the pump sequencing supervisor
package pss_pkg;
	localparam int PUMPS = 3;
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
	localparam logic [31:0] SEC_PER_TENTH_HOUR = 32'h0000_0168;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_START_DLY = 8'h04;
	localparam logic [7:0] ADDR_STOP_DLY = 8'h08;
	localparam logic [7:0] ADDR_CONF_TO = 8'h0c;
	localparam logic [7:0] ADDR_SEAL_DLY = 8'h10;
	localparam logic [7:0] ADDR_RUN_LIMIT = 8'h14;
	localparam logic [7:0] ADDR_ORDER = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_FAULT_CLR = 8'h20;
	localparam logic [7:0] ADDR_DEMAND = 8'h24;
	localparam logic [7:0] ADDR_CMD = 8'h28;
	localparam logic [7:0] ADDR_STATS = 8'h40;
	// command bits, status field positions
	localparam int CMD_ADVANCE = 0;
	localparam int CMD_CLEAR_STATS = 1;
	localparam int STAT_CALL = 0;
	localparam int STAT_FAILED = 4;
	localparam int STAT_OVERTEMP = 8;
	localparam int STAT_SEAL = 12;
	localparam int STAT_RUN_FAIL = 16;
	localparam int STAT_LEAD = 20;
	// reset values, timings in seconds except the run limit in tenths of an hour
	localparam logic [15:0] START_DLY_RST = 16'h0005;
	localparam logic [15:0] STOP_DLY_RST = 16'h0003;
	localparam logic [15:0] CONF_TO_RST = 16'h000a;
	localparam logic [15:0] SEAL_DLY_RST = 16'h000a;
	localparam logic [15:0] RUN_LIMIT_RST = 16'h00f0;
	localparam logic [5:0] ORDER_RST = 6'h24;
	localparam logic [1:0] DEMAND_RST = 2'h0;
	typedef struct packed {
		logic rotate;
		logic makeFirst;
		logic failOnSeal;
		logic sealEn;
		logic otActiveLow;
		logic otEn;
		logic confEn;
	} pss_ctrl_t;
	localparam pss_ctrl_t CTRL_RST = 7'h40;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} pss_wb_req_t;
endpackage : pss_pkg

// File: logic/pss_supervisor.sv
// pump sequencing supervisor with wishbone register slave
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - each further pump start waits the start spacing since the previous start
// - after power-up the lead pump call also waits the start spacing
// - each further pump stop waits the stop spacing since the previous stop
// - unconfirmed call past the timeout raises alarm, fails pump, calls replacement
// - run-confirm timeout check only acts while monitoring is enabled
// - a pump running longer than the run limit is stopped, alternate started
// - seal derivation: on temperature input rising, wait decision delay, sample run-confirm
// - pump stopped at the sample means over-temperature
// - pump still running at the sample means seal failure
// - seal decision delay is set in seconds, default ten, from input rising
// - fail-on-seal option fails pump and drops its call on seal failure
// - configured order is fixed order, or starting order when rotating
// - make-first advance energises the alternate before dropping the running pump
// - break-first advance drops the running pump before energising the alternate
// - manual advance makes the next pump in rotation the lead
// - clear-statistics zeroes every pump's run time and start count
// - active temperature input with monitoring enabled and seal derivation off drops pump from service
// - polarity setting picks active level of the temperature input
module pss_supervisor #(
	parameter int N = pss_pkg::PUMPS,
	parameter int TickCycles = pss_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire pss_pkg::pss_wb_req_t wbReq,
	output logic wbAck,
	output logic [31:0] wbDat,
	input wire logic [N-1:0] runConfirm,
	input wire logic [N-1:0] tempSeal,
	output logic [N-1:0] pumpCall,
	output logic [N-1:0] pumpFailed,
	output logic [N-1:0] runFailAlarm,
	output logic [N-1:0] overTempFlag,
	output logic [N-1:0] sealFailFlag
);
	function automatic logic [1:0] nextPos(input logic [1:0] p);
		return (p == 2'(N - 1)) ? 2'h0 : p + 2'h1;
	endfunction : nextPos
	function automatic logic [1:0] popCnt(input logic [N-1:0] v);
		logic [1:0] c;
		c = 2'h0;
		for (int i = 0; i < N; i++) begin
			c = c + 2'(v[i]);
		end
		return c;
	endfunction : popCnt
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16
	pss_pkg::pss_ctrl_t ctrlFf;
	logic ackFf, cmdAdvFf, cmdClrFf, tickFf, wrEn, fltClr;
	logic startPick, stopPick, startFire, stopFire, runLimHit, doAdvance;
	logic [31:0] datFf, tickCntFf, limSec;
	logic [15:0] startDlyFf, stopDlyFf, confToFf, sealDlyFf, runLimFf, startGapFf, stopGapFf;
	logic [5:0] orderFf;
	logic [1:0] demandFf, leadFf, nCalled, nxt_lead, startSel, stopSel;
	logic [N-1:0] runMetaFf, runSyncFf, tempMetaFf, tempSyncFf, tempActDlyFf;
	logic [N-1:0] callFf, failedFf, runFailFf, overTempFf, sealFf, sealBusyFf;
	logic [N-1:0] tempAct, unavail, want, nxt_call, fltClrMask;
	logic [15:0] confCntFf [N], sealCntFf [N], startsFf [N];
	logic [31:0] runSecFf [N], runTotFf [N];

	assign wrEn = wbReq.cyc && wbReq.stb && wbReq.we && !ackFf;
	assign fltClr = wrEn && wbReq.adr == pss_pkg::ADDR_FAULT_CLR;
	assign fltClrMask = fltClr ? wbReq.dat[N-1:0] : '0;
	assign tempAct = tempSyncFf ^ {N{ctrlFf.otActiveLow}};
	assign unavail = failedFf | (overTempFf & {N{ctrlFf.otEn}});
	assign nCalled = popCnt(callFf);
	assign limSec = 32'(runLimFf) * pss_pkg::SEC_PER_TENTH_HOUR;

	// pin synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			runMetaFf <= '0;
			runSyncFf <= '0;
			tempMetaFf <= '0;
			tempSyncFf <= '0;
			tempActDlyFf <= '0;
		end else begin
			runMetaFf <= runConfirm;
			runSyncFf <= runMetaFf;
			tempMetaFf <= tempSeal;
			tempSyncFf <= tempMetaFf;
			tempActDlyFf <= tempAct;
		end
	end
	// one-second tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCntFf <= '0;
			tickFf <= 1'b0;
		end else begin
			tickFf <= tickCntFf == 32'(TickCycles - 1);
			tickCntFf <= (tickCntFf == 32'(TickCycles - 1)) ? '0 : tickCntFf + 32'h1;
		end
	end
	// wishbone slave
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackFf <= 1'b0;
			datFf <= '0;
		end else begin
			ackFf <= wbReq.cyc && wbReq.stb && !ackFf;
			datFf <= '0;
			case (wbReq.adr)
				pss_pkg::ADDR_CTRL: datFf <= 32'(ctrlFf);
				pss_pkg::ADDR_START_DLY: datFf <= 32'(startDlyFf);
				pss_pkg::ADDR_STOP_DLY: datFf <= 32'(stopDlyFf);
				pss_pkg::ADDR_CONF_TO: datFf <= 32'(confToFf);
				pss_pkg::ADDR_SEAL_DLY: datFf <= 32'(sealDlyFf);
				pss_pkg::ADDR_RUN_LIMIT: datFf <= 32'(runLimFf);
				pss_pkg::ADDR_ORDER: datFf <= 32'(orderFf);
				pss_pkg::ADDR_DEMAND: datFf <= 32'(demandFf);
				pss_pkg::ADDR_STATUS: begin
					datFf[pss_pkg::STAT_CALL +: N] <= callFf;
					datFf[pss_pkg::STAT_FAILED +: N] <= failedFf;
					datFf[pss_pkg::STAT_OVERTEMP +: N] <= overTempFf;
					datFf[pss_pkg::STAT_SEAL +: N] <= sealFf;
					datFf[pss_pkg::STAT_RUN_FAIL +: N] <= runFailFf;
					datFf[pss_pkg::STAT_LEAD +: 2] <= leadFf;
				end
				default: begin
					for (int i = 0; i < N; i++) begin
						if (wbReq.adr == pss_pkg::ADDR_STATS + 8'(8 * i)) begin
							datFf <= runTotFf[i];
						end
						if (wbReq.adr == pss_pkg::ADDR_STATS + 8'(8 * i + 4)) begin
							datFf <= 32'(startsFf[i]);
						end
					end
				end
			endcase
		end
	end
	// configuration registers and one-shot commands
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrlFf <= pss_pkg::CTRL_RST;
			startDlyFf <= pss_pkg::START_DLY_RST;
			stopDlyFf <= pss_pkg::STOP_DLY_RST;
			confToFf <= pss_pkg::CONF_TO_RST;
			sealDlyFf <= pss_pkg::SEAL_DLY_RST;
			runLimFf <= pss_pkg::RUN_LIMIT_RST;
			orderFf <= pss_pkg::ORDER_RST;
			demandFf <= pss_pkg::DEMAND_RST;
			cmdAdvFf <= 1'b0;
			cmdClrFf <= 1'b0;
		end else begin
			cmdAdvFf <= 1'b0;
			cmdClrFf <= 1'b0;
			if (wrEn) begin
				case (wbReq.adr)
					pss_pkg::ADDR_CTRL: if (wbReq.sel[0]) ctrlFf <= wbReq.dat[6:0];
					pss_pkg::ADDR_START_DLY: startDlyFf <= merge16(startDlyFf, wbReq.dat, wbReq.sel);
					pss_pkg::ADDR_STOP_DLY: stopDlyFf <= merge16(stopDlyFf, wbReq.dat, wbReq.sel);
					pss_pkg::ADDR_CONF_TO: confToFf <= merge16(confToFf, wbReq.dat, wbReq.sel);
					pss_pkg::ADDR_SEAL_DLY: sealDlyFf <= merge16(sealDlyFf, wbReq.dat, wbReq.sel);
					pss_pkg::ADDR_RUN_LIMIT: runLimFf <= merge16(runLimFf, wbReq.dat, wbReq.sel);
					pss_pkg::ADDR_ORDER: if (wbReq.sel[0]) orderFf <= wbReq.dat[5:0];
					pss_pkg::ADDR_DEMAND: if (wbReq.sel[0]) demandFf <= wbReq.dat[1:0];
					pss_pkg::ADDR_CMD: begin
						cmdAdvFf <= wbReq.sel[0] && wbReq.dat[pss_pkg::CMD_ADVANCE];
						cmdClrFf <= wbReq.sel[0] && wbReq.dat[pss_pkg::CMD_CLEAR_STATS];
					end
					default: ;
				endcase
			end
		end
	end
	// wanted pumps from the lead along the order, start and stop picks
	always_comb begin
		logic [1:0] pos, p, cnt;
		pos = leadFf;
		p = 2'h0;
		cnt = 2'h0;
		want = '0;
		startPick = 1'b0;
		startSel = 2'h0;
		stopPick = 1'b0;
		stopSel = 2'h0;
		for (int k = 0; k < N; k++) begin
			p = orderFf[2 * pos +: 2];
			if (!unavail[p] && cnt < demandFf) begin
				want[p] = 1'b1;
				cnt = cnt + 2'h1;
				if (!callFf[p] && !startPick) begin
					startPick = 1'b1;
					startSel = p;
				end
			end
			pos = nextPos(pos);
		end
		for (int i = N - 1; i >= 0; i--) begin
			if (callFf[i] && !want[i] && !unavail[i]) begin
				stopPick = 1'b1;
				stopSel = 2'(i);
			end
		end
	end
	assign startFire = startPick && startGapFf >= startDlyFf &&
		(ctrlFf.makeFirst ? nCalled <= demandFf : nCalled < demandFf);
	assign stopFire = stopPick && stopGapFf >= stopDlyFf &&
		(!ctrlFf.makeFirst || nCalled > demandFf);
	always_comb begin
		runLimHit = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (callFf[i] && tickFf && runSecFf[i] == limSec) begin
				runLimHit = 1'b1;
			end
		end
	end
	assign doAdvance = cmdAdvFf || runLimHit || (ctrlFf.rotate && stopFire && nCalled == 2'h1 && demandFf == 2'h0);
	assign nxt_lead = doAdvance ? nextPos(leadFf) : leadFf;
	always_comb begin
		nxt_call = callFf & ~unavail;
		if (startFire) begin
			nxt_call[startSel] = 1'b1;
		end
		if (stopFire) begin
			nxt_call[stopSel] = 1'b0;
		end
	end
	// pump calls, spacing timers, lead
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			callFf <= '0;
			leadFf <= 2'h0;
			startGapFf <= '0;
			stopGapFf <= '0;
		end else begin
			callFf <= nxt_call;
			leadFf <= nxt_lead;
			if (startFire) begin
				startGapFf <= '0;
			end else if (tickFf && startGapFf != 16'hffff) begin
				startGapFf <= startGapFf + 16'h1;
			end
			if (stopFire) begin
				stopGapFf <= '0;
			end else if (tickFf && stopGapFf != 16'hffff) begin
				stopGapFf <= stopGapFf + 16'h1;
			end
		end
	end
	// run confirm, seal derivation and fault flags
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			failedFf <= '0;
			runFailFf <= '0;
			overTempFf <= '0;
			sealFf <= '0;
			sealBusyFf <= '0;
			for (int i = 0; i < N; i++) begin
				confCntFf[i] <= '0;
				sealCntFf[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				logic fSet, rSet, oSet, sSet;
				fSet = 1'b0;
				rSet = 1'b0;
				oSet = 1'b0;
				sSet = 1'b0;
				if (!ctrlFf.confEn || !callFf[i] || runSyncFf[i]) begin
					confCntFf[i] <= '0;
				end else if (tickFf) begin
					confCntFf[i] <= confCntFf[i] + 16'h1;
					if (confCntFf[i] + 16'h1 >= confToFf) begin
						rSet = 1'b1;
						fSet = 1'b1;
					end
				end
				if (ctrlFf.sealEn && tempAct[i] && !tempActDlyFf[i]) begin
					sealBusyFf[i] <= 1'b1;
					sealCntFf[i] <= '0;
				end else if (sealBusyFf[i] && tickFf) begin
					sealCntFf[i] <= sealCntFf[i] + 16'h1;
					if (sealCntFf[i] + 16'h1 >= sealDlyFf) begin
						sealBusyFf[i] <= 1'b0;
						if (runSyncFf[i]) begin
							sSet = 1'b1;
							fSet = ctrlFf.failOnSeal;
						end else begin
							oSet = 1'b1;
						end
					end
				end
				if (!ctrlFf.sealEn && ctrlFf.otEn && tempAct[i]) begin
					oSet = 1'b1;
				end
				failedFf[i] <= (failedFf[i] && !fltClrMask[i]) || fSet;
				runFailFf[i] <= (runFailFf[i] && !fltClrMask[i]) || rSet;
				overTempFf[i] <= (overTempFf[i] && !fltClrMask[i]) || oSet;
				sealFf[i] <= (sealFf[i] && !fltClrMask[i]) || sSet;
			end
		end
	end

	// run time and start statistics
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < N; i++) begin
				runSecFf[i] <= '0;
				runTotFf[i] <= '0;
				startsFf[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				runSecFf[i] <= !callFf[i] ? '0 : runSecFf[i] + 32'(tickFf);
				if (cmdClrFf) begin
					runTotFf[i] <= '0;
					startsFf[i] <= '0;
				end else begin
					runTotFf[i] <= runTotFf[i] + 32'(tickFf && callFf[i]);
					startsFf[i] <= startsFf[i] + 16'(startFire && startSel == 2'(i));
				end
			end
		end
	end

	assign wbAck = ackFf;
	assign wbDat = datFf;
	assign pumpCall = callFf;
	assign pumpFailed = failedFf;
	assign runFailAlarm = runFailFf;
	assign overTempFlag = overTempFf;
	assign sealFailFlag = sealFf;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_start_spacing: assert property ((callFf & ~$past(callFf)) != '0 |->
		$past(startGapFf) >= $past(startDlyFf)) else $error("pump started inside start spacing");
	a_stop_spacing: assert property ((~callFf & $past(callFf) & ~$past(unavail)) != '0 |->
		$past(stopGapFf) >= $past(stopDlyFf)) else $error("pump stopped inside stop spacing");
	a_conf_fail: assert property ($rose(runFailFf[0]) |-> failedFf[0] ##1 !callFf[0])
		else $error("run confirm failure did not drop pump");
	a_conf_enable: assert property ($rose(runFailFf[0]) |-> $past(ctrlFf.confEn))
		else $error("run confirm failure while monitoring disabled");
	a_ot_class: assert property ($past(ctrlFf.sealEn) |->
		(overTempFf & ~$past(overTempFf) & $past(runSyncFf)) == '0) else $error("over-temperature while pump running");
	a_seal_class: assert property ($rose(sealFf[0]) |-> $past(runSyncFf[0]) && $past(sealBusyFf[0]))
		else $error("seal failure without running pump");
	a_seal_fails: assert property ($rose(sealFf[0]) && $past(ctrlFf.failOnSeal) |-> failedFf[0] ##1 !callFf[0])
		else $error("seal failure did not fail pump");
	a_break_first: assert property ((callFf & ~$past(callFf)) != '0 && !$past(ctrlFf.makeFirst) |->
		$past(nCalled) < $past(demandFf)) else $error("break-first start before stop");
	a_make_first: assert property ((~callFf & $past(callFf) & ~$past(unavail)) != '0 && $past(ctrlFf.makeFirst) |->
		$past(nCalled) > $past(demandFf)) else $error("make-first stop before start");
	a_manual_adv: assert property (cmdAdvFf |=> leadFf == nextPos($past(leadFf)))
		else $error("manual advance did not move lead");
	a_clear_stats: assert property (cmdClrFf |=> runTotFf[0] == '0 && startsFf[0] == '0)
		else $error("statistics not cleared");
	a_ot_drop: assert property (overTempFf[0] && ctrlFf.otEn |=> !callFf[0])
		else $error("over-temperature pump still called");
	a_cmd_once: assert property (cmdAdvFf || cmdClrFf |=> !cmdAdvFf && !cmdClrFf)
		else $error("command not one-shot");
	a_tick_once: assert property (tickFf |=> !tickFf)
		else $error("tick wider than one cycle");
endmodule : pss_supervisor

// File: dv/pss_pump_model.sv
// motor starter and contact model facing the supervisor
`timescale 1ns/100ps
module pss_pump_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [2:0] pumpCall,
	input wire logic [2:0] holdOff,
	input wire logic [2:0] hot,
	input wire logic [2:0] leak,
	input wire logic activeLow,
	input wire logic [7:0] lagCycles,
	output logic [2:0] runConfirm,
	output logic [2:0] tempSeal
);
	logic [7:0] lagCnt [3];
	// both sensors share one contact, or'd
	assign tempSeal = (hot | leak) ^ {3{activeLow}};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lagCnt <= '{default: 8'h00};
			runConfirm <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (!pumpCall[i] || holdOff[i] || hot[i]) begin // external stop on over-temperature
					lagCnt[i] <= 8'h00;
					runConfirm[i] <= 1'b0;
				end else if (lagCnt[i] < lagCycles) begin
					lagCnt[i] <= lagCnt[i] + 8'h01;
				end else begin
					runConfirm[i] <= 1'b1;
				end
			end
		end
	end
endmodule : pss_pump_model

// File: dv/tb_pss_supervisor.sv
// self-checking bench for the pump sequencing supervisor
`timescale 1ns/100ps
module tb_pss_supervisor;
	localparam int T = 10;
	localparam int CNT = 5;
	localparam logic [7:0] ADR [9] = '{pss_pkg::ADDR_CTRL, pss_pkg::ADDR_START_DLY, pss_pkg::ADDR_STOP_DLY,
		pss_pkg::ADDR_CONF_TO, pss_pkg::ADDR_SEAL_DLY, pss_pkg::ADDR_RUN_LIMIT, pss_pkg::ADDR_ORDER,
		pss_pkg::ADDR_DEMAND, 8'h3c};
	localparam logic [31:0] RSTV [9] = '{32'h40, 32'h5, 32'h3, 32'ha, 32'ha, 32'hf0, 32'h24, 32'h1, 32'h0};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	pss_pkg::pss_wb_req_t wbReq = '0;
	logic wbAck;
	logic [31:0] wbDat;
	logic [2:0] runConfirm, tempSeal, pumpCall, pumpFailed, runFailAlarm, overTempFlag, sealFailFlag;
	logic [2:0] holdOff = 3'h0, hot = 3'h0, leak = 3'h0, p, q;
	logic activeLow = 1'b0;
	logic [7:0] lag = 8'h02;
	logic [31:0] rd;
	int nFail = 0, nChecks = 0, cyc = 0, t0;
	bit sawTwo, sawNone;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if ($countones(pumpCall) > 1) sawTwo = 1'b1;
		if (pumpCall == 3'h0) sawNone = 1'b1;
	end
	pss_supervisor #(.TickCycles(T)) pss_supervisor_inst (.clk(clk), .rst_b(rst_b), .wbReq(wbReq), .wbAck(wbAck),
		.wbDat(wbDat), .runConfirm(runConfirm), .tempSeal(tempSeal), .pumpCall(pumpCall), .pumpFailed(pumpFailed),
		.runFailAlarm(runFailAlarm), .overTempFlag(overTempFlag), .sealFailFlag(sealFailFlag));
	pss_pump_model pss_pump_model_inst (.clk(clk), .rst_b(rst_b), .pumpCall(pumpCall), .holdOff(holdOff),
		.hot(hot), .leak(leak), .activeLow(activeLow), .lagCycles(lag), .runConfirm(runConfirm), .tempSeal(tempSeal));
	task wrap_up;
		if (nFail == 0 && nChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task chkIn(input int v, input int lo, input int hi);
		chk(32'(v >= lo && v <= hi), 32'h1);
	endtask : chkIn
	// classic single cycle, held until ack is sampled
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wbReq <= '{1'b1, 1'b1, we, 4'hf, a, d};
		do @(posedge clk); while (wbAck !== 1'b1);
		rd = wbDat;
		wbReq <= '0;
	endtask : wb
	function automatic logic [2:0] pick(input int w);
		case (w)
			0: return pumpCall;
			1: return runFailAlarm;
			2: return pumpFailed;
			3: return overTempFlag;
			4: return sealFailFlag;
			default: return 3'($countones(pumpCall));
		endcase
	endfunction : pick
	task waitOut(input int w, input logic [2:0] v, input int sec);
		int n;
		n = 0;
		while (pick(w) !== v && n < sec * T) begin
			@(posedge clk);
			n++;
		end
		chk(32'(pick(w)), 32'(v));
	endtask : waitOut
	task secs(input int s);
		repeat (s * T) @(posedge clk);
	endtask : secs
	initial begin
		repeat (12000) @(posedge clk);
		nFail++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t0 = cyc;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h1);
		for (int i = 0; i < 9; i++) begin
			wb(1'b0, ADR[i], 32'h0);
			chk(rd, RSTV[i]);
		end
		waitOut(0, 3'b001, 6);
		chkIn(cyc - t0, 4 * T, 6 * T + 4);
		t0 = cyc;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h2);
		waitOut(0, 3'b011, 7);
		chkIn(cyc - t0, 4 * T, 6 * T + 4);
		// fixed order, stop spacing
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h0);
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h0);
		waitOut(CNT, 3'h1, 5);
		t0 = cyc;
		waitOut(CNT, 3'h0, 5);
		chkIn(cyc - t0, 2 * T, 4 * T + 4);
		wb(1'b1, pss_pkg::ADDR_ORDER, 32'h12);
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h1);
		waitOut(0, 3'b100, 7);
		secs(2);
		// break-first advance
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h40);
		sawTwo = 1'b0;
		sawNone = 1'b0;
		wb(1'b1, pss_pkg::ADDR_CMD, 32'h1);
		waitOut(0, 3'b001, 12);
		chk(32'(sawNone), 32'h1);
		chk(32'(sawTwo), 32'h0);
		secs(3);
		wb(1'b0, pss_pkg::ADDR_STATUS, 32'h0);
		chk(32'(rd[21:20]), 32'h1);
		// make-first advance
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h60);
		sawTwo = 1'b0;
		sawNone = 1'b0;
		wb(1'b1, pss_pkg::ADDR_CMD, 32'h1);
		waitOut(0, 3'b010, 12);
		t0 = cyc;
		chk(32'(sawTwo), 32'h1);
		chk(32'(sawNone), 32'h0);
		// run limit of one tenth hour
		wb(1'b1, pss_pkg::ADDR_RUN_LIMIT, 32'h1);
		waitOut(CNT, 3'h2, 370);
		chkIn(cyc - t0, 358 * T, 364 * T);
		waitOut(CNT, 3'h1, 10);
		chk(32'(pumpCall[1]), 32'h0);
		wb(1'b1, pss_pkg::ADDR_RUN_LIMIT, 32'hf0);
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h0);
		waitOut(CNT, 3'h0, 10);
		// run confirm timeout
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h0);
		holdOff <= 3'h7;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h1);
		waitOut(CNT, 3'h1, 10);
		p = pumpCall;
		secs(15);
		chk(32'(runFailAlarm | pumpFailed), 32'h0);
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h1);
		waitOut(1, p, 12);
		chk(32'(pumpFailed), 32'(p));
		secs(4);
		chk(32'(pumpCall & p), 32'h0);
		chk(32'($countones(pumpCall)), 32'h1);
		holdOff <= 3'h0;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h0);
		wb(1'b1, pss_pkg::ADDR_FAULT_CLR, 32'h7);
		waitOut(CNT, 3'h0, 10);
		// over-temperature, inverted sense
		activeLow <= 1'b1;
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h6);
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h1);
		waitOut(CNT, 3'h1, 10);
		p = pumpCall;
		secs(2);
		chk(32'(overTempFlag), 32'h0);
		hot <= p;
		waitOut(3, p, 2);
		@(posedge clk);
		chk(32'(pumpCall & p), 32'h0);
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h0);
		hot <= 3'h0;
		activeLow <= 1'b0;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h0);
		wb(1'b1, pss_pkg::ADDR_FAULT_CLR, 32'h7);
		waitOut(CNT, 3'h0, 10);
		// seal derivation, slow run contacts
		lag <= 8'h28;
		wb(1'b1, pss_pkg::ADDR_CTRL, 32'h1b);
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h1);
		waitOut(CNT, 3'h1, 10);
		p = pumpCall;
		secs(5);
		leak <= p;
		secs(8);
		chk(32'(sealFailFlag), 32'h0);
		waitOut(4, p, 4);
		chk(32'(overTempFlag), 32'h0);
		secs(1);
		chk(32'(pumpFailed & p), 32'(p));
		chk(32'(pumpCall & p), 32'h0);
		leak <= 3'h0;
		waitOut(CNT, 3'h1, 8);
		q = pumpCall;
		secs(6);
		chk(32'(runFailAlarm), 32'h0);
		hot <= q;
		secs(12);
		chk(32'(overTempFlag & q), 32'(q));
		chk(32'(sealFailFlag & q), 32'h0);
		hot <= 3'h0;
		wb(1'b1, pss_pkg::ADDR_DEMAND, 32'h0);
		waitOut(CNT, 3'h0, 10);
		// statistics clear
		wb(1'b0, pss_pkg::ADDR_STATS + 8'h04, 32'h0);
		chk(32'(rd != 32'h0), 32'h1);
		wb(1'b1, pss_pkg::ADDR_CMD, 32'h2);
		for (int i = 0; i < 6; i++) begin
			wb(1'b0, pss_pkg::ADDR_STATS + 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		wrap_up();
	end
endmodule : tb_pss_supervisor
